/* hdl/adcrf_regs.sv */
// result and front-end register bank behind the serial register port
`timescale 1ns/1ps
module adcrf_regs #(
    parameter int CODE_W = 24
) (
    input wire logic clock, // system clock, 100 MHz
    input wire logic rst, // asynchronous reset, active high
    input wire logic sample_rate_clock, // one-cycle data-ready event for both channels
    input wire logic [CODE_W-1:0] raw_code_a, // raw conversion result, channel a
    input wire logic [CODE_W-1:0] raw_code_b, // raw conversion result, channel b
    input wire logic comp_valid, // one-cycle pulse: new comparator outputs
    input wire logic [3:0] comparators_a, // modulator comparators, channel a
    input wire logic [3:0] comparators_b, // modulator comparators, channel b
    input wire logic offset_correction_on, // offset correction enable
    input wire logic scale_correction_on, // scale correction enable
    input wire logic [CODE_W-1:0] offset_a, // offset value, channel a
    input wire logic [CODE_W-1:0] offset_b, // offset value, channel b
    input wire logic [CODE_W-1:0] scale_a, // scale fraction, channel a
    input wire logic [CODE_W-1:0] scale_b, // scale fraction, channel b
    input wire logic [1:0] read_loop, // read address-loop setting
    input wire logic write_loop, // write address-loop: 1 increments
    input wire logic xact_start, // one-cycle pulse: transaction begins
    input wire logic xact_read, // with xact_start: 1 read, 0 write
    input wire logic [4:0] xact_addr, // with xact_start: first address
    input wire logic xact_end, // one-cycle pulse: transaction ends
    input wire logic rd_byte, // one-cycle pulse: fetch next byte
    input wire logic wr_byte, // one-cycle pulse: store wr_data
    input wire logic [7:0] wr_data, // byte to store
    output logic [7:0] rd_data, // fetched byte
    output logic rd_valid, // one-cycle pulse: rd_data fresh
    output logic restart, // one-cycle pulse: converter reset and restart
    output logic [11:0] delay_setting, // signed channel a delay, master clock periods
    output logic [1:0] bias_select, // bias current scale
    output logic [2:0] amp_a_select, // amplifier a gain code
    output logic [2:0] amp_b_select // amplifier b gain code
);

    adcrf_pkg::adcrf_state_e state;
    logic [4:0] ptr;
    logic [CODE_W-1:0] result_channel_a;
    logic [CODE_W-1:0] result_channel_b;
    logic [CODE_W-1:0] shadow_a;
    logic [CODE_W-1:0] shadow_b;
    logic [7:0] comparator_snapshot;
    logic [1:0] corr_valid;
    logic [CODE_W-1:0] corr_code [2];
    logic [CODE_W-1:0] raw_code [2];
    logic [CODE_W-1:0] offset_value [2];
    logic [CODE_W-1:0] scale_value [2];
    logic word_start;
    logic [CODE_W-1:0] src_a;
    logic [CODE_W-1:0] src_b;

    assign raw_code[0] = raw_code_a;
    assign raw_code[1] = raw_code_b;
    assign offset_value[0] = offset_a;
    assign offset_value[1] = offset_b;
    assign scale_value[0] = scale_a;
    assign scale_value[1] = scale_b;

    // ------------------------------------------------------------
    // correction stages, one per channel
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_corr
        adcrf_corrector #(.W(CODE_W)) u_corr (
            .clock(clock),
            .rst(rst),
            .load(sample_rate_clock),
            .raw_code(raw_code[ch]),
            .offset_correction_on(offset_correction_on),
            .scale_correction_on(scale_correction_on),
            .offset_value(offset_value[ch]),
            .scale_value(scale_value[ch]),
            .out_valid(corr_valid[ch]),
            .output_code(corr_code[ch])
        );
    end

    // live results: whole 24-bit word replaced at once, never a byte at a time
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            result_channel_a <= '0;
            result_channel_b <= '0;
        end else begin
            if (corr_valid[0]) result_channel_a <= corr_code[0];
            if (corr_valid[1]) result_channel_b <= corr_code[1];
        end
    end

    // ------------------------------------------------------------
    // read shadow
    // ------------------------------------------------------------
    // a fetch at a result word's first byte takes the live word, so a mid-read
    // update lands on the next word but never splits the current one
    assign word_start = (ptr == adcrf_pkg::ADDR_RESULT_A) || (ptr == adcrf_pkg::ADDR_RESULT_B);
    assign src_a = word_start ? result_channel_a : shadow_a;
    assign src_b = word_start ? result_channel_b : shadow_b;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shadow_a <= '0;
            shadow_b <= '0;
        end else if (xact_start) begin
            shadow_a <= result_channel_a;
            shadow_b <= result_channel_b;
        end else if (state == adcrf_pkg::ADCRF_READ && rd_byte && word_start) begin
            shadow_a <= result_channel_a;
            shadow_b <= result_channel_b;
        end
    end

    // byte view of the bank; addresses outside it read zero
    function automatic logic [7:0] fetch(input logic [4:0] p, input logic [CODE_W-1:0] a,
                                         input logic [CODE_W-1:0] b);
        unique case (p)
            adcrf_pkg::ADDR_RESULT_A: return a[23:16];
            adcrf_pkg::ADDR_RESULT_A + 5'h01: return a[15:8];
            adcrf_pkg::ADDR_RESULT_A + 5'h02: return a[7:0];
            adcrf_pkg::ADDR_RESULT_B: return b[23:16];
            adcrf_pkg::ADDR_RESULT_B + 5'h01: return b[15:8];
            adcrf_pkg::ADDR_RESULT_B + 5'h02: return b[7:0];
            adcrf_pkg::ADDR_SNAPSHOT: return comparator_snapshot;
            adcrf_pkg::ADDR_DELAY_HI: return {4'h0, delay_setting[11:8]};
            adcrf_pkg::ADDR_DELAY_LO: return delay_setting[7:0];
            adcrf_pkg::ADDR_SETUP: return {bias_select, amp_b_select, amp_a_select};
            default: return 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // transaction state and address pointer
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= adcrf_pkg::ADCRF_IDLE;
            ptr <= '0;
        end else if (xact_start) begin
            state <= xact_read ? adcrf_pkg::ADCRF_READ : adcrf_pkg::ADCRF_WRITE;
            ptr <= xact_addr;
        end else if (xact_end) begin
            state <= adcrf_pkg::ADCRF_IDLE;
        end else begin
            unique case (state)
                adcrf_pkg::ADCRF_IDLE: ptr <= ptr;
                adcrf_pkg::ADCRF_READ: if (rd_byte) ptr <= adcrf_pkg::adcrf_next_read(ptr, read_loop);
                adcrf_pkg::ADCRF_WRITE: begin
                    // write loop wraps within the writable part of the map
                    if (wr_byte && write_loop) ptr <= (ptr >= adcrf_pkg::ADDR_LAST) ?
                        adcrf_pkg::ADDR_SNAPSHOT : ptr + 5'h01;
                end
                default: state <= adcrf_pkg::ADCRF_IDLE;
            endcase
        end
    end

    // read data register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= (state == adcrf_pkg::ADCRF_READ) && rd_byte;
            if (state == adcrf_pkg::ADCRF_READ && rd_byte) rd_data <= fetch(ptr, src_a, src_b);
        end
    end

    // ------------------------------------------------------------
    // writable settings
    // ------------------------------------------------------------
    // comparator update wins over a host write in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            comparator_snapshot <= adcrf_pkg::SNAPSHOT_RESET;
        end else if (comp_valid) begin
            comparator_snapshot <= {comparators_b, comparators_a};
        end else if (state == adcrf_pkg::ADCRF_WRITE && wr_byte && ptr == adcrf_pkg::ADDR_SNAPSHOT) begin
            comparator_snapshot <= wr_data;
        end
    end

    // delay, bias and gain; result addresses fall through untouched
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            delay_setting <= adcrf_pkg::DELAY_RESET;
            bias_select <= adcrf_pkg::BIAS_RESET;
            amp_b_select <= adcrf_pkg::AMP_RESET;
            amp_a_select <= adcrf_pkg::AMP_RESET;
        end else if (state == adcrf_pkg::ADCRF_WRITE && wr_byte) begin
            if (ptr == adcrf_pkg::ADDR_DELAY_HI) delay_setting[11:8] <= wr_data[adcrf_pkg::DELAY_HI_W-1:0];
            if (ptr == adcrf_pkg::ADDR_DELAY_LO) delay_setting[7:0] <= wr_data;
            if (ptr == adcrf_pkg::ADDR_SETUP) begin
                bias_select <= wr_data[adcrf_pkg::BIAS_LSB +: 2];
                amp_b_select <= wr_data[adcrf_pkg::AMP_B_LSB +: 3];
                amp_a_select <= wr_data[adcrf_pkg::AMP_A_LSB +: 3];
            end
        end
    end

    // restart pulse for a write to either delay byte
    always_ff @(posedge clock or posedge rst) begin
        if (rst) restart <= 1'b0;
        else restart <= (state == adcrf_pkg::ADCRF_WRITE) && wr_byte &&
            (ptr == adcrf_pkg::ADDR_DELAY_HI || ptr == adcrf_pkg::ADDR_DELAY_LO);
    end

endmodule // adcrf_regs

/* hdl/adcrf_pkg.sv */
// package of register map constants and address-loop helpers for the result and front-end bank
package adcrf_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int CODE_W = 24;
    localparam logic [4:0] ADDR_RESULT_A = 5'h00;
    localparam logic [4:0] ADDR_RESULT_B = 5'h03;
    localparam logic [4:0] ADDR_SNAPSHOT = 5'h06;
    localparam logic [4:0] ADDR_DELAY_HI = 5'h07;
    localparam logic [4:0] ADDR_DELAY_LO = 5'h08;
    localparam logic [4:0] ADDR_SETUP = 5'h09;
    localparam logic [4:0] ADDR_CONFIG_A = 5'h0C;
    localparam logic [4:0] ADDR_CAL_A = 5'h0E;
    localparam logic [4:0] ADDR_CAL_B = 5'h14;
    localparam logic [4:0] ADDR_LAST = 5'h1A;
    localparam logic [4:0] ADDR_STATUS = 5'h0A;

    // ------------------------------------------------------------
    // reset values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] SNAPSHOT_RESET = 8'h33;
    localparam logic [11:0] DELAY_RESET = 12'h000;
    localparam logic [1:0] BIAS_RESET = 2'h2;
    localparam logic [2:0] AMP_RESET = 3'h0;
    localparam int BIAS_LSB = 6;
    localparam int AMP_B_LSB = 3;
    localparam int AMP_A_LSB = 0;
    localparam int DELAY_HI_W = 4;
    localparam int SCALE_SHIFT = 23;

    // ------------------------------------------------------------
    // address-loop settings
    // ------------------------------------------------------------
    localparam logic [1:0] LOOP_SINGLE = 2'h0;
    localparam logic [1:0] LOOP_GROUP = 2'h1;
    localparam logic [1:0] LOOP_TYPE = 2'h2;
    localparam logic [1:0] LOOP_ALL = 2'h3;

    typedef enum logic [1:0] {
        ADCRF_IDLE = 2'h0,
        ADCRF_READ = 2'h1,
        ADCRF_WRITE = 2'h3
    } adcrf_state_e;

    // first and last address of the group holding p
    function automatic logic [4:0] adcrf_group_first(input logic [4:0] p);
        if (p < ADDR_RESULT_B) return ADDR_RESULT_A;
        else if (p < ADDR_SNAPSHOT) return ADDR_RESULT_B;
        else if (p < ADDR_SETUP) return ADDR_SNAPSHOT;
        else if (p < ADDR_CONFIG_A) return ADDR_SETUP;
        else if (p < ADDR_CAL_A) return ADDR_CONFIG_A;
        else if (p < ADDR_CAL_B) return ADDR_CAL_A;
        else if (p < ADDR_LAST) return ADDR_CAL_B;
        else return ADDR_LAST;
    endfunction

    function automatic logic [4:0] adcrf_group_last(input logic [4:0] p);
        if (p < ADDR_RESULT_B) return ADDR_RESULT_B - 5'h01;
        else if (p < ADDR_SNAPSHOT) return ADDR_SNAPSHOT - 5'h01;
        else if (p < ADDR_SETUP) return ADDR_SETUP - 5'h01;
        else if (p < ADDR_CONFIG_A) return ADDR_CONFIG_A - 5'h01;
        else if (p < ADDR_CAL_A) return ADDR_CAL_A - 5'h01;
        else if (p < ADDR_CAL_B) return ADDR_CAL_B - 5'h01;
        else if (p < ADDR_LAST) return ADDR_LAST - 5'h01;
        else return ADDR_LAST;
    endfunction

    // read pointer step for each address-loop setting
    function automatic logic [4:0] adcrf_next_read(input logic [4:0] p, input logic [1:0] m);
        unique case (m)
            LOOP_SINGLE: return p;
            LOOP_GROUP: return (p == adcrf_group_last(p)) ? adcrf_group_first(p) : p + 5'h01;
            LOOP_TYPE: begin
                if (p < ADDR_SNAPSHOT) return (p == ADDR_SNAPSHOT - 5'h01) ? ADDR_RESULT_A : p + 5'h01;
                else return (p >= ADDR_LAST) ? ADDR_SNAPSHOT : p + 5'h01;
            end
            LOOP_ALL: return (p >= ADDR_LAST) ? ADDR_RESULT_A : p + 5'h01;
        endcase
    endfunction

endpackage

/* hdl/adcrf_corrector.sv */
// one channel's offset and scale correction stage, registered
`timescale 1ns/1ps
module adcrf_corrector #(
    parameter int W = 24
) (
    input wire logic clock, // system clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic load, // one-cycle pulse: new raw code
    input wire logic [W-1:0] raw_code, // raw two's-complement code
    input wire logic offset_correction_on, // add offset before scaling
    input wire logic scale_correction_on, // apply scale fraction
    input wire logic [W-1:0] offset_value, // signed offset
    input wire logic [W-1:0] scale_value, // signed fraction of full scale
    output logic out_valid, // one-cycle pulse: output_code updated
    output logic [W-1:0] output_code // corrected code
);

    localparam logic signed [W+1:0] MAX_CODE = (W+2)'((1 <<< (W-1)) - 1);
    localparam logic signed [W+1:0] MIN_CODE = -(W+2)'(1 <<< (W-1));

    logic signed [W+1:0] shifted;
    logic signed [2*W+1:0] product;
    logic signed [W+1:0] scaled;
    logic signed [W+1:0] next_code;

    // ------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------
    // offset adds no latency; both adds and the multiply are combinational, keeping the stage to one cycle
    always_comb begin
        shifted = (W+2)'($signed(raw_code));
        if (offset_correction_on) shifted = shifted + (W+2)'($signed(offset_value));
        product = (2*W+2)'(shifted) * (2*W+2)'($signed(scale_value));
        scaled = shifted + (W+2)'(product >>> adcrf_pkg::SCALE_SHIFT);
        next_code = scale_correction_on ? scaled : shifted;
        // saturate rather than wrap so a large offset cannot flip the sign
        if (next_code > MAX_CODE) next_code = MAX_CODE;
        else if (next_code < MIN_CODE) next_code = MIN_CODE;
    end

    // output register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            output_code <= '0;
        end else begin
            out_valid <= load;
            if (load) output_code <= next_code[W-1:0];
        end
    end

endmodule // adcrf_corrector

/* bench/adcrf_regs_sva.sv */
// checker of port timing and reset values for the result and front-end bank
`timescale 1ns/1ps
module adcrf_regs_sva #(
    parameter int CODE_W = 24
) (
    input logic clock, // system clock
    input logic rst, // asynchronous reset
    input logic rd_byte, // fetch strobe
    input logic wr_byte, // store strobe
    input logic [7:0] rd_data, // fetched byte
    input logic rd_valid, // fetch answer
    input logic restart, // converter restart pulse
    input logic [11:0] delay_setting, // channel delay
    input logic [1:0] bias_select, // bias scale
    input logic [2:0] amp_a_select, // amplifier a code
    input logic [2:0] amp_b_select // amplifier b code
);
    // ------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // answers and restarts only ever follow their strobe by one cycle
    fetch_answer_a: assert property (rd_valid |-> $past(rd_byte))
        else $error("fetch answer without a strobe");
    restart_cause_a: assert property (restart |-> $past(wr_byte))
        else $error("restart without a store");
    dir_apart_a: assert property (!(rd_valid && restart))
        else $error("fetch answer and restart together");
    // a delay change always comes with its restart; setup changes never restart
    delay_write_a: assert property ($changed(delay_setting) |-> restart && $past(wr_byte))
        else $error("delay changed without a restart");
    setup_write_a: assert property ($changed({bias_select, amp_b_select, amp_a_select}) |-> !restart)
        else $error("setup changed with a restart");
    // fetched byte holds between answers, so the host reads one coherent word
    data_hold_a: assert property (!rd_valid |-> $stable(rd_data))
        else $error("read data moved without a fetch");
    // values right after reset release
    reset_setup_a: assert property ($fell(rst) |-> bias_select == 2'h2 && {amp_b_select, amp_a_select} == 6'h00)
        else $error("setup reset value wrong");
    reset_delay_a: assert property ($fell(rst) |-> delay_setting == 12'h000 && rd_data == 8'h00)
        else $error("delay reset value wrong");
    cover property (restart ##[1:20] restart);
endmodule // adcrf_regs_sva

bind adcrf_regs adcrf_regs_sva #(.CODE_W(CODE_W)) u_sva (.clock(clock), .rst(rst), .rd_byte(rd_byte),
    .wr_byte(wr_byte), .rd_data(rd_data), .rd_valid(rd_valid), .restart(restart), .delay_setting(delay_setting),
    .bias_select(bias_select), .amp_a_select(amp_a_select), .amp_b_select(amp_b_select));

/* bench/adcrf_host.sv */
// host model driving the strobed register port
`timescale 1ns/1ps
module adcrf_host (
    input logic clock, // system clock
    input logic [7:0] rd_data, // fetched byte
    input logic rd_valid, // fetch answer
    output logic xact_start, // transaction begins
    output logic xact_read, // 1 read, 0 write
    output logic [4:0] xact_addr, // first address
    output logic xact_end, // transaction ends
    output logic rd_byte, // fetch strobe
    output logic wr_byte, // store strobe
    output logic [7:0] wr_data // byte to store
);
    // ------------------------------------------------------------
    // transactions
    // ------------------------------------------------------------
    logic [7:0] got [0:11]; // bytes of the last read
    // idle port from time zero
    initial begin
        {xact_start, xact_read, xact_end, rd_byte, wr_byte, xact_addr, wr_data} = 18'h00000;
    end
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    // address and direction held through the edge that takes them
    task automatic open_x(input logic rd, input logic [4:0] a);
        tick();
        {xact_start, xact_read, xact_addr} = {1'b1, rd, a};
        tick();
        xact_start = 1'b0;
    endtask
    task automatic close_x;
        xact_end = 1'b1;
        tick();
        xact_end = 1'b0;
    endtask
    // one strobe every other cycle; a missing answer leaves an unknown byte
    task automatic rd(input logic [4:0] a, input int n);
        open_x(1'b1, a);
        for (int i = 0; i < n; i++) begin
            rd_byte = 1'b1;
            tick();
            rd_byte = 1'b0;
            got[i] = (rd_valid === 1'b1) ? rd_data : 8'hXX;
            tick();
        end
        close_x();
    endtask
    // single-byte store; the snapshot is never a target, it would spoil accuracy
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        open_x(1'b0, a);
        {wr_byte, wr_data} = {1'b1, d};
        tick();
        wr_byte = 1'b0;
        close_x();
    endtask
    // two back-to-back stores in one transaction; the pointer steps as write_loop says
    task automatic wr2(input logic [4:0] a, input logic [15:0] d);
        open_x(1'b0, a);
        for (int i = 1; i >= 0; i--) begin
            {wr_byte, wr_data} = {1'b1, d[8*i +: 8]};
            tick();
        end
        wr_byte = 1'b0;
        close_x();
    endtask
endmodule // adcrf_host

/* bench/tb_adcrf_regs.sv */
// self-checking bench for the result and front-end register bank
`timescale 1ns/1ps
module tb_adcrf_regs;
    // ------------------------------------------------------------
    // signals, design and host
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sample_rate_clock, comp_valid, offset_correction_on, scale_correction_on, write_loop;
    logic [1:0] read_loop;
    logic [3:0] comparators_a, comparators_b;
    logic [23:0] raw_code_a, raw_code_b, offset_a, offset_b, scale_a, scale_b;
    logic xact_start, xact_read, xact_end, rd_byte, wr_byte, rd_valid, restart;
    logic [4:0] xact_addr;
    logic [7:0] wr_data, rd_data;
    logic [11:0] delay_setting;
    logic [1:0] bias_select;
    logic [2:0] amp_a_select, amp_b_select;
    logic [4:0] lp_addr [0:3] = '{5'h01, 5'h02, 5'h05, 5'h1A};
    logic [15:0] lp_exp [0:3] = '{16'h3434, 16'h5612, 16'hEF12, 16'h0012};
    int error_cnt = 0, n_tests = 0, restart_cnt = 0, cyc = 0;

    adcrf_regs #(.CODE_W(24)) dut (.clock(clock), .rst(rst), .sample_rate_clock(sample_rate_clock),
        .raw_code_a(raw_code_a), .raw_code_b(raw_code_b), .comp_valid(comp_valid), .comparators_a(comparators_a),
        .comparators_b(comparators_b), .offset_correction_on(offset_correction_on),
        .scale_correction_on(scale_correction_on), .offset_a(offset_a), .offset_b(offset_b), .scale_a(scale_a),
        .scale_b(scale_b), .read_loop(read_loop), .write_loop(write_loop), .xact_start(xact_start),
        .xact_read(xact_read), .xact_addr(xact_addr), .xact_end(xact_end), .rd_byte(rd_byte), .wr_byte(wr_byte),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .restart(restart),
        .delay_setting(delay_setting), .bias_select(bias_select), .amp_a_select(amp_a_select),
        .amp_b_select(amp_b_select));
    adcrf_host host (.clock(clock), .rd_data(rd_data), .rd_valid(rd_valid), .xact_start(xact_start),
        .xact_read(xact_read), .xact_addr(xact_addr), .xact_end(xact_end), .rd_byte(rd_byte),
        .wr_byte(wr_byte), .wr_data(wr_data));

    always #5 clock = ~clock;
    // restart pulses counted; the cycle ceiling is far above the roughly 190 cycles needed
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (restart === 1'b1) restart_cnt <= restart_cnt + 1;
        if (cyc == 5000) begin
            error_cnt++;
            $display("BAD %0t: timeout", $time);
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // expected bytes right-aligned in e, first byte read is the most significant
    task automatic rdchk(input logic [4:0] a, input int n, input logic [95:0] e);
        host.rd(a, n);
        for (int i = 0; i < n; i++) chk({16'h0000, host.got[i]}, {16'h0000, e[8*(n-1-i) +: 8]});
    endtask
    // one data-ready event, then time for the correction stage to settle
    task automatic sample(input logic [23:0] a, input logic [23:0] b);
        {raw_code_a, raw_code_b, sample_rate_clock} = {a, b, 1'b1};
        tick(1);
        sample_rate_clock = 1'b0;
        tick(3);
    endtask

    initial begin
        {sample_rate_clock, comp_valid, offset_correction_on, scale_correction_on, write_loop} = 5'h01;
        {read_loop, comparators_a, comparators_b} = {adcrf_pkg::LOOP_ALL, 8'h00};
        {raw_code_a, raw_code_b, offset_a, offset_b, scale_a, scale_b} = 144'h0;
        tick(4);
        rst = 1'b0;
        rdchk(adcrf_pkg::ADDR_RESULT_A, 11, 96'h0000000000003300008000);
        sample(24'h123456, 24'hABCDEF);
        read_loop = adcrf_pkg::LOOP_TYPE;
        rdchk(adcrf_pkg::ADDR_RESULT_A, 7, 96'h123456ABCDEF12);
        for (int k = 0; k < 4; k++) begin
            read_loop = 2'(k);
            rdchk(lp_addr[k], 2, {80'h0, lp_exp[k]});
        end
        // a conversion lands between the first and second byte of a word
        read_loop = adcrf_pkg::LOOP_TYPE;
        fork
            rdchk(adcrf_pkg::ADDR_RESULT_A, 3, 96'h123456);
            begin
                tick(3);
                sample(24'h654321, 24'h000000);
            end
        join
        rdchk(adcrf_pkg::ADDR_RESULT_A, 6, 96'h654321000000);
        {offset_correction_on, scale_correction_on, offset_a, scale_b} = {2'h3, 24'h000010, 24'h400000};
        sample(24'h000100, 24'h000100);
        rdchk(adcrf_pkg::ADDR_RESULT_A, 6, 96'h000110000180);
        {comparators_b, comparators_a, comp_valid} = {8'hA5, 1'b1};
        tick(1);
        comp_valid = 1'b0;
        rdchk(adcrf_pkg::ADDR_SNAPSHOT, 1, 96'hA5);
        host.wr(adcrf_pkg::ADDR_DELAY_HI, 8'hFF);
        host.wr(adcrf_pkg::ADDR_DELAY_LO, 8'hA5);
        tick(1);
        chk(24'(delay_setting), 24'h000FA5);
        chk(24'(restart_cnt), 24'h000002);
        rdchk(adcrf_pkg::ADDR_DELAY_HI, 2, 96'h0FA5);
        host.wr(adcrf_pkg::ADDR_SETUP, 8'hED);
        tick(1);
        chk({16'h0000, bias_select, amp_b_select, amp_a_select}, 24'h0000ED);
        host.wr(adcrf_pkg::ADDR_RESULT_A, 8'hFF);
        host.wr(5'h02, 8'hFF);
        rdchk(adcrf_pkg::ADDR_RESULT_A, 3, 96'h000110);
        chk(24'(restart_cnt), 24'h000002);
        // static write pointer: both bytes land on the setup register, the last one stays
        write_loop = 1'b0;
        host.wr2(adcrf_pkg::ADDR_SETUP, 16'h3F52);
        // stepping write pointer: one transaction fills both delay bytes, two restarts
        write_loop = 1'b1;
        host.wr2(adcrf_pkg::ADDR_DELAY_HI, 16'h0123);
        tick(1);
        chk({4'h0, delay_setting, bias_select, amp_b_select, amp_a_select}, 24'h012352);
        chk(24'(restart_cnt), 24'h000004);
        // second reset in mid-run brings every setting back
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        rdchk(adcrf_pkg::ADDR_SNAPSHOT, 4, 96'h33000080);
        test_done();
    end
endmodule // tb_adcrf_regs
